// ==== rtl/swc_cfg.svh ====
// Purpose: constants for suspend and warm-up control
// Assumes: 250 MHz system clock
// Notes: offsets are byte addresses on APB
`ifndef SWC_CFG_SVH
`define SWC_CFG_SVH
// Register indices and byte addresses
`define SWC_PWRCTL_IDX 12'h087
`define SWC_KEY_IDX 12'h08E
`define SWC_OPT_IDX 12'h090
`define SWC_STAT_IDX 12'h091
`define SWC_PWRCTL_ADDR (`SWC_PWRCTL_IDX * 4)
`define SWC_KEY_ADDR (`SWC_KEY_IDX * 4)
`define SWC_OPT_ADDR (`SWC_OPT_IDX * 4)
`define SWC_STAT_ADDR (`SWC_STAT_IDX * 4)
// Power control fields
`define SWC_PC_BAUD 7
`define SWC_PC_VIEW 6
`define SWC_PC_FHI 3
`define SWC_PC_FLO 2
`define SWC_PC_SLEEP 1
`define SWC_PC_HALT 0
`define SWC_PC_MASK 8'hCF
`define SWC_PWRCTL_RST 8'h00
`define SWC_KEY_RST 8'h00
`define SWC_KEY_VAL 8'h55
// Option fields
`define SWC_OPT_WLEN 1:0
`define SWC_OPT_DOG 2
`define SWC_OPT_DOGSLP 3
`define SWC_OP_RSTPIN 4
`define SWC_OP_BOEN 5
`define SWC_OP_BOLVL 6
`define SWC_OPT_MON 7
`define SWC_OP_LED 8
`define SWC_OPT_SRC 15:12
`define SWC_OPT_RST 16'h0000
`define SWC_OPT_MASK 16'hF1FF
// Timing
`define SWC_CLK_MHZ 250
`define SWC_T_POR_US 11000
`define SWC_T_WDT_US 1000
`define SWC_T_WAKE_US 800
`endif

// ==== rtl/swc_pkg.sv ====
// Purpose: types for suspend and warm-up control
// Assumes: nothing
// Notes: state and clock source codes
package swc_pkg;
  typedef enum logic [2:0] {
    SWC_INIT = 3'h0,
    SWC_PWR = 3'h1,
    SWC_OSC = 3'h2,
    SWC_RUN = 3'h3,
    SWC_IDLE = 3'h4,
    SWC_DOWN = 3'h5
  } swc_state_e;
  typedef enum logic [1:0] {
    SWC_SRC_OFF = 2'h0,
    SWC_SRC_RC12M = 2'h1,
    SWC_SRC_RC128K = 2'h2,
    SWC_SRC_X32K = 2'h3
  } swc_src_e;
  typedef logic [2:0] swc_pair_t;
endpackage : swc_pkg

// ==== rtl/swc_top.sv ====
// Purpose: suspend entry, wake and warm-up sequencing over APB
// Assumes: APB master in clk domain; osc_pin from oscillator pad
// Notes: one APB transfer stands for one instruction
`include "swc_cfg.svh"

module swc_top #(
  parameter int POR_CYC = `SWC_T_POR_US * `SWC_CLK_MHZ,
  parameter int WDT_CYC = `SWC_T_WDT_US * `SWC_CLK_MHZ,
  parameter int WAKE_CYC = `SWC_T_WAKE_US * `SWC_CLK_MHZ
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Reset cause and wake sources
  input wire logic rst_by_wdt,
  input wire logic wdt_in_pd,
  input wire logic irq_wake,
  input wire logic ext_irq_wake,
  input wire logic osc_pin,
  // Clock gating
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic osc_run,
  output logic core_ready,
  // Serial controls
  output logic baud_double,
  output logic serial_ctrl_view_select,
  // Option driven controls
  output logic wdt_run,
  output logic reset_pin_is_io,
  output logic brownout_enable,
  output logic brownout_level,
  output logic clock_monitor_en,
  output logic led_common_invert,
  output logic [1:0] osc_primary,
  output logic [1:0] osc_secondary
);

  // Oscillator warm-up length in oscillator periods
  function automatic logic [17:0] osc_len(input logic [15:0] opt);
    logic [17:0] n;
    n = 18'h00080;
    if (src_pri(opt[`SWC_OPT_SRC]) == 2'h3)
      n = 18'h02000;
    else if (src_pri(opt[`SWC_OPT_SRC]) == 2'h0)
    begin
      unique case (opt[`SWC_OPT_WLEN])
        2'h0: n = 18'h20000;
        2'h1: n = 18'h04000;
        2'h2: n = 18'h00800;
        2'h3: n = 18'h00100;
      endcase
    end
    return n;
  endfunction

  // Primary source: 0 high-speed crystal, 1 RC12M, 2 RC128K, 3 X32K
  function automatic logic [1:0] src_pri(input logic [3:0] c);
    logic [1:0] s;
    s = 2'h1;
    unique case (c)
      4'h3, 4'h6: s = 2'h2;
      4'hA, 4'hD: s = 2'h3;
      4'hE: s = 2'h0;
      default: s = 2'h1;
    endcase
    return s;
  endfunction

  swc_pkg::swc_state_e state_q;
  swc_pkg::swc_state_e state_d;
  logic [7:0] pwr_ctl_q;
  logic [7:0] key_q;
  logic armed_q;
  logic bad_q;
  logic go_q;
  logic [15:0] opt_q;
  logic osc_after_q;
  logic [21:0] pwr_cnt_q;
  logic [17:0] osc_cnt_q;
  logic osc_s1_q;
  logic osc_s2_q;
  logic osc_s3_q;
  logic osc_tick;
  logic fire;
  logic wr_fire;
  logic hit_pwr;
  logic hit_key;
  logic hit_opt;
  logic hit_stat;
  logic req_bits;
  logic wake_done;
  logic [1:0] sec;

  // Address decode
  assign hit_pwr = paddr == 12'(`SWC_PWRCTL_ADDR);
  assign hit_key = paddr == 12'(`SWC_KEY_ADDR);
  assign hit_opt = paddr == 12'(`SWC_OPT_ADDR);
  assign hit_stat = paddr == 12'(`SWC_STAT_ADDR);
  assign fire = psel & penable & pready;
  assign wr_fire = fire & pwrite;
  assign req_bits = pwdata[`SWC_PC_SLEEP] | pwdata[`SWC_PC_HALT];

  // APB answer one cycle into access phase
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      pready <= 1'b0;
    else
      pready <= psel & penable & ~pready;
  end

  // Read data and error for unmapped addresses
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else if (psel & penable & ~pready)
    begin
      pslverr <= ~(hit_pwr | hit_key | hit_opt | hit_stat);
      prdata <= 32'h00000000;
      if (!pwrite)
      begin
        if (hit_pwr)
          prdata <= {24'h000000, pwr_ctl_q};
        else if (hit_key)
          prdata <= {24'h000000, key_q};
        else if (hit_opt)
          prdata <= {16'h0000, opt_q};
        else if (hit_stat)
          prdata <= {28'h0000000, osc_after_q, state_q};
      end
    end
    else
    begin
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
  end

  // Oscillator pad synchroniser and edge detect
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      osc_s1_q <= 1'b0;
      osc_s2_q <= 1'b0;
      osc_s3_q <= 1'b0;
    end
    else
    begin
      osc_s1_q <= osc_pin;
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
    end
  end
  assign osc_tick = osc_s2_q & ~osc_s3_q;

  // Code option register
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      opt_q <= `SWC_OPT_RST;
    else if (wr_fire & hit_opt)
      opt_q <= pwdata[15:0] & `SWC_OPT_MASK;
  end

  // Suspend key register
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      key_q <= `SWC_KEY_RST;
      armed_q <= 1'b0;
    end
    else if (wr_fire & hit_key)
    begin
      key_q <= pwdata[7:0];
      armed_q <= pwdata[7:0] == `SWC_KEY_VAL;
    end
    else if (wake_done)
    begin
      key_q <= `SWC_KEY_RST;
      armed_q <= 1'b0;
    end
    else if (fire & armed_q)
    begin
      armed_q <= 1'b0;
      if (!(wr_fire & hit_pwr & req_bits))
        key_q <= `SWC_KEY_RST;
    end
  end

  // Suspend go and broken-order flags
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      go_q <= 1'b0;
      bad_q <= 1'b0;
    end
    else
    begin
      // accept request only right after key
      go_q <= wr_fire & hit_pwr & req_bits & armed_q;
      bad_q <= wr_fire & hit_pwr & req_bits & ~armed_q;
    end
  end

  // Power control register
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      pwr_ctl_q <= `SWC_PWRCTL_RST;
    else if (wr_fire & hit_pwr)
      pwr_ctl_q <= pwdata[7:0] & `SWC_PC_MASK;
    else if (bad_q)
    begin
      pwr_ctl_q[`SWC_PC_SLEEP] <= 1'b0;
      pwr_ctl_q[`SWC_PC_HALT] <= 1'b0;
    end
    else if (wake_done)
    begin
      pwr_ctl_q[`SWC_PC_SLEEP] <= 1'b0;
      pwr_ctl_q[`SWC_PC_HALT] <= 1'b0;
    end
  end

  // Exit from idle, or end of warm-up after reset or power-down
  assign wake_done = (state_q == swc_pkg::SWC_IDLE && irq_wake) ||
    (state_q != swc_pkg::SWC_RUN && state_q != swc_pkg::SWC_IDLE &&
    state_q != swc_pkg::SWC_DOWN && state_d == swc_pkg::SWC_RUN);

  // Sequencer next state
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      swc_pkg::SWC_INIT:
        state_d = swc_pkg::SWC_PWR;
      swc_pkg::SWC_PWR:
      begin
        if (pwr_cnt_q == 22'h000000)
          state_d = osc_after_q ? swc_pkg::SWC_OSC :
            swc_pkg::SWC_RUN;
      end
      swc_pkg::SWC_OSC:
      begin
        if (osc_tick && osc_cnt_q == 18'h00000)
          state_d = swc_pkg::SWC_RUN;
      end
      swc_pkg::SWC_RUN:
      begin
        if (go_q && pwr_ctl_q[`SWC_PC_SLEEP])
          state_d = swc_pkg::SWC_DOWN;
        else if (go_q)
          state_d = swc_pkg::SWC_IDLE;
      end
      swc_pkg::SWC_IDLE:
      begin
        if (irq_wake)
          state_d = swc_pkg::SWC_RUN;
      end
      swc_pkg::SWC_DOWN:
      begin
        if (ext_irq_wake)
          state_d = swc_pkg::SWC_PWR;
      end
      default:
        state_d = swc_pkg::SWC_INIT;
    endcase
  end

  // Sequencer state register
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      state_q <= swc_pkg::SWC_INIT;
    else
      state_q <= state_d;
  end

  // Power warm-up counter and oscillator follow-on flag
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pwr_cnt_q <= 22'h000000;
      osc_after_q <= 1'b1;
    end
    else if (state_q == swc_pkg::SWC_INIT)
    begin
      if (rst_by_wdt)
      begin
        pwr_cnt_q <= 22'(WDT_CYC - 1);
        osc_after_q <= wdt_in_pd;
      end
      else
      begin
        pwr_cnt_q <= 22'(POR_CYC - 1);
        osc_after_q <= 1'b1;
      end
    end
    else if (state_q == swc_pkg::SWC_DOWN && ext_irq_wake)
    begin
      pwr_cnt_q <= 22'(WAKE_CYC - 1);
      osc_after_q <= 1'b1;
    end
    else if (state_q == swc_pkg::SWC_PWR &&
      pwr_cnt_q != 22'h000000)
      pwr_cnt_q <= pwr_cnt_q - 22'h000001;
  end

  // Oscillator warm-up counter in oscillator periods
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      osc_cnt_q <= 18'h00000;
    else if (state_q != swc_pkg::SWC_OSC)
      osc_cnt_q <= osc_len(opt_q) - 18'h00001;
    else if (osc_tick && osc_cnt_q != 18'h00000)
      osc_cnt_q <= osc_cnt_q - 18'h00001;
  end

  // Clock enables and core release
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cpu_clk_en <= 1'b0;
      periph_clk_en <= 1'b0;
      osc_run <= 1'b0;
      core_ready <= 1'b0;
    end
    else
    begin
      cpu_clk_en <= state_d == swc_pkg::SWC_RUN;
      periph_clk_en <= state_d == swc_pkg::SWC_RUN ||
        state_d == swc_pkg::SWC_IDLE;
      osc_run <= state_d != swc_pkg::SWC_DOWN &&
        state_d != swc_pkg::SWC_PWR;
      core_ready <= state_d == swc_pkg::SWC_RUN ||
        state_d == swc_pkg::SWC_IDLE || state_d == swc_pkg::SWC_DOWN;
    end
  end

  // Serial controls from power control bits
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      baud_double <= 1'b0;
      serial_ctrl_view_select <= 1'b0;
    end
    else
    begin
      baud_double <= pwr_ctl_q[`SWC_PC_BAUD];
      serial_ctrl_view_select <= pwr_ctl_q[`SWC_PC_VIEW];
    end
  end

  // Secondary source from oscillator option
  always_comb
  begin
    sec = 2'h0;
    unique case (opt_q[`SWC_OPT_SRC])
      4'h3, 4'hA: sec = 2'h1;
      4'h6, 4'hD: sec = 2'h2;
      default: sec = 2'h0;
    endcase
  end

  // Option driven controls
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wdt_run <= 1'b0;
      reset_pin_is_io <= 1'b0;
      brownout_enable <= 1'b0;
      brownout_level <= 1'b0;
      clock_monitor_en <= 1'b0;
      led_common_invert <= 1'b0;
      osc_primary <= 2'h1;
      osc_secondary <= 2'h0;
    end
    else
    begin
      wdt_run <= opt_q[`SWC_OPT_DOG] &
        (state_d != swc_pkg::SWC_DOWN | opt_q[`SWC_OPT_DOGSLP]);
      reset_pin_is_io <= opt_q[`SWC_OP_RSTPIN];
      brownout_enable <= opt_q[`SWC_OP_BOEN];
      brownout_level <= opt_q[`SWC_OP_BOLVL];
      // monitor in warm-up only by option
      clock_monitor_en <= (state_d == swc_pkg::SWC_PWR ||
        state_d == swc_pkg::SWC_OSC) ? opt_q[`SWC_OPT_MON] : 1'b1;
      led_common_invert <= opt_q[`SWC_OP_LED];
      osc_primary <= src_pri(opt_q[`SWC_OPT_SRC]);
      osc_secondary <= sec;
    end
  end

endmodule // swc_top

// ==== tb/swc_top_assertions.sv ====
// Purpose: port checks for swc_top
// Assumes: one clock domain, nrst async low
// Notes: bound into every swc_top
`include "swc_cfg.svh"
module swc_top_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Wake and clock controls
  input wire logic irq_wake,
  input wire logic ext_irq_wake,
  input wire logic cpu_clk_en,
  input wire logic periph_clk_en,
  input wire logic osc_run,
  input wire logic core_ready,
  input wire logic baud_double,
  input wire logic serial_ctrl_view_select
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // Steps of a transfer and power states
  sequence s_wait;
    psel && penable && !pready;
  endsequence
  sequence s_pc_wr;
    psel && penable && pready && pwrite
      && paddr == 12'(`SWC_PWRCTL_ADDR);
  endsequence
  sequence s_down;
    core_ready && !periph_clk_en;
  endsequence
  sequence s_idle;
    core_ready && periph_clk_en && !cpu_clk_en;
  endsequence
  apb_one_wait_a: assert property (s_wait |=> pready)
    else $error("pready not after one wait");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held too long");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  rdata_quiet_a: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero outside answer");
  baud_copy_a: assert property (
    s_pc_wr |-> ##2 baud_double == $past(pwdata[7], 2))
    else $error("baud_double not following write");
  view_copy_a: assert property (
    s_pc_wr |-> ##2 serial_ctrl_view_select == $past(pwdata[6], 2))
    else $error("view select not following write");
  idle_gate_a: assert property (cpu_clk_en |-> periph_clk_en)
    else $error("cpu clock without peripheral clock");
  down_stop_a: assert property (s_down |-> !osc_run && !cpu_clk_en)
    else $error("clocks running in power-down");
  idle_wake_a: assert property (s_idle ##0 irq_wake |=> cpu_clk_en)
    else $error("idle not left on interrupt");
  down_wake_a: assert property (
    s_down ##0 ext_irq_wake |=> !core_ready [*4])
    else $error("power-down wake skipped warm-up");
endmodule // swc_top_chk

bind swc_top swc_top_chk swc_top_chk_i (
  .clk(clk),
  .nrst(nrst),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .irq_wake(irq_wake),
  .ext_irq_wake(ext_irq_wake),
  .cpu_clk_en(cpu_clk_en),
  .periph_clk_en(periph_clk_en),
  .osc_run(osc_run),
  .core_ready(core_ready),
  .baud_double(baud_double),
  .serial_ctrl_view_select(serial_ctrl_view_select)
);

// ==== tb/swc_cpu_model.sv ====
// Purpose: CPU side issuing register accesses over APB
// Assumes: one transfer stands for one instruction
// Notes: released address and data lines show inverted values
module swc_cpu_model (
  // Clock
  input wire logic clk,
  // APB master
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus at time zero
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end
  task automatic xfer(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] r,
    output logic e, output logic to);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    to = 1'b1;
    for (int i = 0; i < 16 && to; i++)
    begin
      @(posedge clk);
      to = (pready !== 1'b1);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule // swc_cpu_model

// ==== tb/swc_top_tb_top.sv ====
// Purpose: self-checking bench for swc_top
// Assumes: short warm-up counts, pad oscillator period 24 ns
// Notes: one task per scenario
`include "swc_cfg.svh"
module swc_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] A_PC = 12'(`SWC_PWRCTL_ADDR);
  localparam logic [11:0] A_KEY = 12'(`SWC_KEY_ADDR);
  localparam logic [11:0] A_OPT = 12'(`SWC_OPT_ADDR);
  localparam logic [11:0] A_ST = 12'(`SWC_STAT_ADDR);
  localparam logic [3:0] OSC_CODE [7] = '{4'h0, 4'h3, 4'h6, 4'hA,
    4'hD, 4'hE, 4'h5};
  localparam logic [1:0] OSC_PRI [7] = '{2'h1, 2'h2, 2'h2, 2'h3,
    2'h3, 2'h0, 2'h1};
  localparam logic [1:0] OSC_SEC [7] = '{2'h0, 2'h1, 2'h2, 2'h1,
    2'h2, 2'h0, 2'h0};
  logic clk, nrst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic rst_by_wdt, wdt_in_pd, irq_wake, ext_irq_wake;
  logic osc_pin, osc_on, er, to;
  logic cpu_clk_en, periph_clk_en, osc_run, core_ready;
  logic baud_double, serial_ctrl_view_select, wdt_run;
  logic reset_pin_is_io, brownout_enable, brownout_level;
  logic clock_monitor_en, led_common_invert;
  logic [1:0] osc_primary, osc_secondary;
  longint t0;
  int cyc;
  int bad_count = 0;
  int n_compared = 0;

  swc_top #(.POR_CYC(20), .WDT_CYC(10), .WAKE_CYC(8)) swc_top_i (
    .clk(clk),
    .nrst(nrst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .rst_by_wdt(rst_by_wdt),
    .wdt_in_pd(wdt_in_pd),
    .irq_wake(irq_wake),
    .ext_irq_wake(ext_irq_wake),
    .osc_pin(osc_pin),
    .cpu_clk_en(cpu_clk_en),
    .periph_clk_en(periph_clk_en),
    .osc_run(osc_run),
    .core_ready(core_ready),
    .baud_double(baud_double),
    .serial_ctrl_view_select(serial_ctrl_view_select),
    .wdt_run(wdt_run),
    .reset_pin_is_io(reset_pin_is_io),
    .brownout_enable(brownout_enable),
    .brownout_level(brownout_level),
    .clock_monitor_en(clock_monitor_en),
    .led_common_invert(led_common_invert),
    .osc_primary(osc_primary),
    .osc_secondary(osc_secondary)
  );

  swc_cpu_model swc_cpu_model_i (
    .clk(clk),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr)
  );

  // System clock, 4 ns
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Oscillator pad, still while osc_on is low
  initial
  begin
    osc_pin = 1'b0;
    forever #12 osc_pin = osc_on & ~osc_pin;
  end

  task automatic tally_and_finish();
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    swc_cpu_model_i.xfer(w, a, d, rd, er, to);
    if (to)
    begin
      bad_count++;
      tally_and_finish();
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Cycles from t0 until warm-up is over
  task automatic wait_ready();
    int n;
    for (n = 0; n < 3000 && core_ready !== 1'b1; n++)
      @(posedge clk);
    cyc = int'(($time - t0) / 4);
    if (n == 3000)
    begin
      bad_count++;
      tally_and_finish();
    end
  endtask

  task automatic do_reset(input logic wdt);
    @(posedge clk);
    nrst <= 1'b0;
    rst_by_wdt <= wdt;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    t0 = $time;
  endtask

  task automatic sc_power_on();
    do_reset(1'b0);
    tick(2);
    chk(osc_run, 1'b0);
    bus(1'b0, A_ST, 32'h0);
    chk(rd[2:0], 3'h1);
    bus(1'b0, A_PC, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, A_KEY, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, 12'h004, 32'h0);
    chk({er, rd[30:0]}, 32'h80000000);
    wait_ready();
    chk(cyc >= 780 && cyc <= 820, 1'b1);
    tick(1);
    chk(cpu_clk_en, 1'b1);
  endtask

  task automatic sc_flags();
    bus(1'b1, A_PC, 32'hCC);
    tick(2);
    chk(baud_double, 1'b1);
    chk(serial_ctrl_view_select, 1'b1);
    bus(1'b1, A_PC, 32'hFF);
    tick(3);
    chk(cpu_clk_en, 1'b1);
    bus(1'b0, A_PC, 32'h0);
    chk(rd, 32'hCC);
    bus(1'b1, A_PC, 32'h00);
  endtask

  task automatic sc_idle();
    bus(1'b1, A_KEY, 32'h55);
    bus(1'b1, A_PC, 32'h01);
    tick(3);
    chk(cpu_clk_en, 1'b0);
    chk(periph_clk_en, 1'b1);
    @(posedge clk);
    irq_wake <= 1'b1;
    tick(2);
    chk(cpu_clk_en, 1'b1);
    @(posedge clk);
    irq_wake <= 1'b0;
    bus(1'b0, A_PC, 32'h0);
    chk(rd[1:0], 2'h0);
    bus(1'b0, A_KEY, 32'h0);
    chk(rd, 32'h0);
  endtask

  task automatic sc_disarm();
    bus(1'b1, A_KEY, 32'h55);
    bus(1'b0, A_ST, 32'h0);
    bus(1'b1, A_PC, 32'h02);
    tick(3);
    chk(cpu_clk_en, 1'b1);
    bus(1'b0, A_KEY, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, A_PC, 32'h0);
    chk(rd[1:0], 2'h0);
  endtask

  task automatic sc_options();
    for (int i = 0; i < 7; i++)
    begin
      bus(1'b1, A_OPT, {16'h0, OSC_CODE[i], 12'h1F0});
      tick(2);
      chk(osc_primary, OSC_PRI[i]);
      chk(osc_secondary, OSC_SEC[i]);
    end
    chk({reset_pin_is_io, brownout_enable}, 2'h3);
    chk({brownout_level, led_common_invert}, 2'h3);
    chk({clock_monitor_en, wdt_run}, 2'h2);
    bus(1'b1, A_OPT, 32'h0004);
    tick(2);
    chk(wdt_run, 1'b1);
    chk({reset_pin_is_io, brownout_enable}, 2'h0);
    chk({brownout_level, led_common_invert}, 2'h0);
  endtask

  task automatic sc_down();
    bus(1'b1, A_OPT, 32'hE007);
    bus(1'b1, A_KEY, 32'h55);
    bus(1'b1, A_PC, 32'h03);
    tick(3);
    chk({periph_clk_en, osc_run}, 2'h0);
    chk(wdt_run, 1'b0);
    osc_on <= 1'b0;
    tick(4);
    ext_irq_wake <= 1'b1;
    osc_on <= 1'b1;
    t0 = $time;
    @(posedge clk);
    ext_irq_wake <= 1'b0;
    tick(2);
    chk(clock_monitor_en, 1'b0);
    chk(osc_run, 1'b0);
    wait_ready();
    chk(cyc >= 1530 && cyc <= 1600, 1'b1);
    tick(1);
    chk({cpu_clk_en, wdt_run}, 2'h3);
    bus(1'b0, A_PC, 32'h0);
    chk(rd[1:0], 2'h0);
    bus(1'b0, A_KEY, 32'h0);
    chk(rd, 32'h0);
  endtask

  task automatic sc_wdt();
    bus(1'b1, A_KEY, 32'h55);
    bus(1'b1, A_PC, 32'h01);
    tick(3);
    osc_on <= 1'b0;
    do_reset(1'b1);
    wait_ready();
    chk(cyc >= 10 && cyc <= 16, 1'b1);
    bus(1'b0, A_PC, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, A_KEY, 32'h0);
    chk(rd, 32'h0);
  endtask

  // Main sequence
  initial
  begin
    nrst = 1'b0;
    rst_by_wdt = 1'b0;
    wdt_in_pd = 1'b0;
    irq_wake = 1'b0;
    ext_irq_wake = 1'b0;
    osc_on = 1'b1;
    sc_power_on();
    sc_flags();
    sc_idle();
    sc_disarm();
    sc_options();
    sc_down();
    sc_wdt();
    tally_and_finish();
  end
endmodule // swc_top_tb_top
